// >>> shared/jdsp_regs.vh
`ifndef JDSP_REGS_VH
`define JDSP_REGS_VH
// Instruction register width and opcodes
`define JDSP_IR_W 4
`define JDSP_OP_EXTEST 4'h0
`define JDSP_OP_IDCODE 4'h1
`define JDSP_OP_SAMPLE 4'h2
`define JDSP_OP_PRIV_A 4'h8
`define JDSP_OP_PRIV_B 4'h9
`define JDSP_OP_PRIV_C 4'hA
`define JDSP_OP_PRIV_D 4'hB
`define JDSP_OP_RESET 4'hC
`define JDSP_OP_BYPASS 4'hF
// Fixed instruction capture pattern
`define JDSP_IR_CAPTURE 4'h1
// Debug comm register layout and reset
`define JDSP_DCR_PEND_BIT 7
`define JDSP_DCR_RESET 8'h00
// Break control layout inside the debug scan word
`define JDSP_BRK_FLOW_BIT 0
`define JDSP_BRK_STEP_BIT 1
`define JDSP_BRK_MODE_LSB 2
// Break point configurations
`define JDSP_BM_4P 3'h0
`define JDSP_BM_3P1D 3'h1
`define JDSP_BM_2P2D 3'h2
`define JDSP_BM_2PPR 3'h3
`define JDSP_BM_2PDR 3'h4
// Programming access command bits
`define JDSP_PRG_CHIP_ERASE 4'h1
`define JDSP_PRG_WR_DEBUG_FUSE 4'h2
`define JDSP_PRG_WR_OTHER 4'h3
`endif

// >>> rtl/jdsp_break_unit.v
`timescale 1ns/1ps
`include "jdsp_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// Four hardware break points, flow and single-step break
module jdsp_break_unit #(
    parameter AW = 16
) (
    input wire sys_clk,
    input wire rst,
    input wire enable,
    input wire [7:0] ctrl,
    input wire [4*AW-1:0] bp_addr,
    input wire cpu_fetch,
    input wire [AW-1:0] cpu_pc,
    input wire cpu_flow_change,
    input wire cpu_data_acc,
    input wire [AW-1:0] cpu_daddr,
    output reg break_req
);
    ////////////////////////////////////////////////////////////////////////////
    // Field pick
    wire [2:0] mode = ctrl[`JDSP_BRK_MODE_LSB+2:`JDSP_BRK_MODE_LSB];
    wire [AW-1:0] a0 = bp_addr[AW-1:0];
    wire [AW-1:0] a1 = bp_addr[2*AW-1:AW];
    wire [AW-1:0] a2 = bp_addr[3*AW-1:2*AW];
    wire [AW-1:0] a3 = bp_addr[4*AW-1:3*AW];
    // Masked compare, mask ones are compared bits
    function hit;
        input [AW-1:0] v;
        input [AW-1:0] a;
        input [AW-1:0] m;
        begin
            hit = ((v ^ a) & m) == {AW{1'b0}};
        end
    endfunction
    wire [AW-1:0] ones = {AW{1'b1}};
    reg next_hit;
    ////////////////////////////////////////////////////////////////////////////
    // Point matching per configuration
    always @* begin
        next_hit = cpu_fetch & (hit(cpu_pc, a0, ones) | hit(cpu_pc, a1, ones));
        case (mode)
            `JDSP_BM_4P: next_hit = next_hit | (cpu_fetch &
                (hit(cpu_pc, a2, ones) | hit(cpu_pc, a3, ones))); // (RULE2)
            `JDSP_BM_3P1D: next_hit = next_hit | (cpu_fetch & hit(cpu_pc, a2, ones))
                | (cpu_data_acc & hit(cpu_daddr, a3, ones)); // (RULE2)
            `JDSP_BM_2P2D: next_hit = next_hit | (cpu_data_acc &
                (hit(cpu_daddr, a2, ones) | hit(cpu_daddr, a3, ones))); // (RULE2)
            `JDSP_BM_2PPR: next_hit = next_hit
                | (cpu_fetch & hit(cpu_pc, a2, a3)); // (RULE2)
            `JDSP_BM_2PDR: next_hit = next_hit
                | (cpu_data_acc & hit(cpu_daddr, a2, a3)); // (RULE2)
            default: next_hit = next_hit;
        endcase
        // Flow change and single step
        if (ctrl[`JDSP_BRK_FLOW_BIT] & cpu_flow_change) begin
            next_hit = 1'b1; // (RULE1)
        end
        if (ctrl[`JDSP_BRK_STEP_BIT] & cpu_fetch) begin
            next_hit = 1'b1; // (RULE1)
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Registered break request
    always @(posedge sys_clk) begin
        if (rst) begin
            break_req <= 1'b0;
        end else begin
            break_req <= enable & next_hit;
        end
    end
endmodule // jdsp_break_unit

// >>> rtl/jdsp_port.v
`timescale 1ns/1ps
`include "jdsp_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// (RULE1) Flow-change and single-step breaks provided
// (RULE2) Four break points, data or range options
// (RULE3) Debugger injects instructions, CPU posts results
// (RULE4) Debug needs both fuses, no lock bits
// (RULE5) Codes 8 to B select debug paths
// (RULE6) Programming uses only four test pins
// (RULE7) Port active: fuse set, disable bit clear
// (RULE8) Flash, EEPROM, fuse, lock programming supported
// (RULE9) Locked: debug fuse refused until erase
// (RULE10) CPU write passes byte, sets pending
// (RULE11) CPU read: seven bits plus pending flag
// (RULE12) Debugger clears pending after reading byte
// (RULE13) Shared address reaches comm register conditionally
// (RULE14) Identification instruction selected by default
// (RULE15) Reset makes port pins high impedance
// (RULE16) Reset from pin or reset register
// (RULE17) EXTEST drives scan latches onto pins
// (RULE18) Tester preloads safe values before EXTEST
// (RULE19) Sample captures pins without disturbing operation
// (RULE20) Scan works with core clock stopped; the scan logic here needs sys_clk running
// (RULE21) Bypass gives one-stage path
// (RULE22) Instruction capture pattern is 0x01
// (RULE23) Four-bit instruction register with decodes
// (RULE24) Reset register holds reset while set
// (RULE25) Bypass cleared on Capture-DR
// (RULE26) Sixteen-state controller, TDO on falling edge
module jdsp_port #(
    parameter NPINS = 8,
    parameter AW = 16,
    parameter [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary identification value
) (
    input wire sys_clk,
    input wire rst,
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo,
    output reg tdo_oe,
    input wire tap_enable_fuse,
    input wire debug_enable_fuse,
    input wire lock_bit_one,
    input wire lock_bit_two,
    input wire tap_disable_bit,
    input wire ext_reset_n,
    output wire cpu_reset,
    input wire cpu_io_wr,
    input wire cpu_io_rd,
    input wire cpu_io_sel,
    input wire [7:0] cpu_io_wdata,
    output reg [7:0] cpu_io_rdata,
    output wire cpu_io_std_sel,
    output reg [15:0] inject_instr,
    output reg inject_strobe,
    input wire cpu_fetch,
    input wire [AW-1:0] cpu_pc,
    input wire cpu_flow_change,
    input wire cpu_data_acc,
    input wire [AW-1:0] cpu_daddr,
    output wire break_req,
    output reg [3:0] prog_cmd,
    output reg [15:0] prog_data,
    output reg prog_strobe,
    input wire [NPINS-1:0] pin_in,
    input wire [NPINS-1:0] core_out,
    input wire [NPINS-1:0] core_oe,
    output reg [NPINS-1:0] pin_out,
    output reg [NPINS-1:0] pin_oe
);
    ////////////////////////////////////////////////////////////////////////////
    // TAP states
    localparam S_TLR = 4'h0, S_RTI = 4'h1, S_SDR = 4'h2, S_CDR = 4'h3;
    localparam S_SHDR = 4'h4, S_E1DR = 4'h5, S_PDR = 4'h6, S_E2DR = 4'h7;
    localparam S_UDR = 4'h8, S_SIR = 4'h9, S_CIR = 4'hA, S_SHIR = 4'hB;
    localparam S_E1IR = 4'hC, S_PIR = 4'hD, S_E2IR = 4'hE, S_UIR = 4'hF;
    localparam DW = 32; // Debug scan word
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, two flops each, three on tck for edge detection
    reg [2:0] tck_s;
    reg [1:0] tms_s, tdi_s, rstn_s;
    reg [NPINS-1:0] pin_s0, pin_s1; // Pin snapshot synchroniser
    always @(posedge sys_clk) begin
        if (rst) begin
            tck_s <= 3'h0;
            tms_s <= 2'h3;
            tdi_s <= 2'h3;
            rstn_s <= 2'h3;
            pin_s0 <= {NPINS{1'b0}};
            pin_s1 <= {NPINS{1'b0}};
        end else begin
            tck_s <= {tck_s[1:0], tck};
            tms_s <= {tms_s[0], tms};
            tdi_s <= {tdi_s[0], tdi};
            rstn_s <= {rstn_s[0], ext_reset_n};
            pin_s0 <= pin_in;
            pin_s1 <= pin_s0;
        end
    end
    wire tck_rise = tck_s[1] & ~tck_s[2];
    wire tck_fall = ~tck_s[1] & tck_s[2];
    wire tms_v = tms_s[1];
    wire tdi_v = tdi_s[1];
    // Port and debug enables
    wire tap_on = tap_enable_fuse & ~tap_disable_bit; // (RULE7)
    wire dbg_on = tap_on & debug_enable_fuse & ~lock_bit_one & ~lock_bit_two; // (RULE4)
    ////////////////////////////////////////////////////////////////////////////
    // TAP state machine on sampled rising edges
    reg [3:0] state;
    reg [3:0] next_state;
    always @* begin
        case (state)
            S_TLR: next_state = tms_v ? S_TLR : S_RTI;
            S_RTI: next_state = tms_v ? S_SDR : S_RTI;
            S_SDR: next_state = tms_v ? S_SIR : S_CDR;
            S_CDR: next_state = tms_v ? S_E1DR : S_SHDR;
            S_SHDR: next_state = tms_v ? S_E1DR : S_SHDR;
            S_E1DR: next_state = tms_v ? S_UDR : S_PDR;
            S_PDR: next_state = tms_v ? S_E2DR : S_PDR;
            S_E2DR: next_state = tms_v ? S_UDR : S_SHDR;
            S_UDR: next_state = tms_v ? S_SDR : S_RTI;
            S_SIR: next_state = tms_v ? S_TLR : S_CIR;
            S_CIR: next_state = tms_v ? S_E1IR : S_SHIR;
            S_SHIR: next_state = tms_v ? S_E1IR : S_SHIR;
            S_E1IR: next_state = tms_v ? S_UIR : S_PIR;
            S_PIR: next_state = tms_v ? S_E2IR : S_PIR;
            S_E2IR: next_state = tms_v ? S_UIR : S_SHIR;
            S_UIR: next_state = tms_v ? S_SDR : S_RTI;
            default: next_state = S_TLR;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // Scan registers, all clocked by sys_clk alone
    reg [`JDSP_IR_W-1:0] ir_sh, ir;
    reg bypass_r, reset_reg;
    reg [31:0] id_sh;
    reg [NPINS-1:0] bs_sh, bs_latch;
    reg [DW-1:0] dbg_sh;
    reg [7:0] brk_ctrl;
    reg [4*AW-1:0] bp_addr;
    reg [19:0] prg_sh;
    reg locked_after_erase;
    reg [7:0] dcr;
    reg pend;
    reg comm_en;
    wire is_dbg = (ir[3:2] == 2'b10); // (RULE5)
    ////////////////////////////////////////////////////////////////////////////
    // Serial output select, least significant bit first
    reg so;
    always @* begin
        so = bypass_r;
        if (state == S_SHIR) begin
            so = ir_sh[0];
        end else begin
            case (ir)
                `JDSP_OP_IDCODE: so = id_sh[0];
                `JDSP_OP_EXTEST, `JDSP_OP_SAMPLE: so = bs_sh[0];
                `JDSP_OP_RESET: so = reset_reg;
                `JDSP_OP_BYPASS: so = bypass_r; // (RULE21)
                default: so = is_dbg ? (dbg_on & dbg_sh[0]) : prg_sh[0];
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // TDO changes on falling edges only
    always @(posedge sys_clk) begin
        if (rst) begin
            tdo <= 1'b1;
            tdo_oe <= 1'b0;
        end else if (!tap_on) begin
            tdo_oe <= 1'b0; // (RULE7)
        end else if (tck_fall) begin
            tdo <= so; // (RULE26)
            tdo_oe <= tap_on & (state == S_SHIR || state == S_SHDR);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Controller and register updates on rising edges
    always @(posedge sys_clk) begin
        inject_strobe <= 1'b0;
        prog_strobe <= 1'b0;
        if (rst || !tap_on) begin
            state <= S_TLR;
            ir <= `JDSP_OP_IDCODE;
            ir_sh <= `JDSP_IR_CAPTURE;
            bypass_r <= 1'b0;
            reset_reg <= 1'b0;
            id_sh <= 32'h0000_0000;
            bs_sh <= {NPINS{1'b0}};
            bs_latch <= {NPINS{1'b0}};
            dbg_sh <= {DW{1'b0}};
            brk_ctrl <= 8'h00;
            bp_addr <= {4*AW{1'b0}};
            prg_sh <= 20'h00000;
            comm_en <= 1'b0;
            inject_instr <= 16'h0000;
            prog_cmd <= 4'h0;
            prog_data <= 16'h0000;
            locked_after_erase <= 1'b0;
        end else if (tck_rise) begin
            state <= next_state; // (RULE26)
            case (state)
                S_TLR: begin
                    ir <= `JDSP_OP_IDCODE; // (RULE14)
                    reset_reg <= 1'b0;
                end
                S_CIR: ir_sh <= `JDSP_IR_CAPTURE; // (RULE22)
                S_SHIR: ir_sh <= {tdi_v, ir_sh[`JDSP_IR_W-1:1]};
                S_UIR: ir <= ir_sh; // (RULE23)
                S_CDR: begin
                    bypass_r <= 1'b0; // (RULE25)
                    id_sh <= ID_VALUE;
                    bs_sh <= pin_s1; // (RULE19)
                    dbg_sh <= {{(DW-8){1'b0}}, pend, dcr[6:0]};
                end
                S_SHDR: begin
                    case (ir)
                        `JDSP_OP_IDCODE: id_sh <= {tdi_v, id_sh[31:1]};
                        `JDSP_OP_EXTEST, `JDSP_OP_SAMPLE:
                            bs_sh <= {tdi_v, bs_sh[NPINS-1:1]};
                        `JDSP_OP_RESET: reset_reg <= tdi_v; // (RULE24)
                        `JDSP_OP_BYPASS: bypass_r <= tdi_v;
                        default: begin
                            if (is_dbg) begin
                                dbg_sh <= {tdi_v, dbg_sh[DW-1:1]};
                            end else begin
                                prg_sh <= {tdi_v, prg_sh[19:1]};
                            end
                        end
                    endcase
                end
                S_UDR: begin
                    if (ir == `JDSP_OP_EXTEST || ir == `JDSP_OP_SAMPLE) begin
                        bs_latch <= bs_sh;
                    end
                    if (is_dbg && dbg_on) begin
                        case (ir)
                            `JDSP_OP_PRIV_A: begin
                                inject_instr <= dbg_sh[15:0]; // (RULE3)
                                inject_strobe <= 1'b1; // (RULE3)
                            end
                            `JDSP_OP_PRIV_B: brk_ctrl <= dbg_sh[7:0]; // (RULE2)
                            `JDSP_OP_PRIV_C: bp_addr[dbg_sh[AW+1:AW]*AW +: AW]
                                <= dbg_sh[AW-1:0];
                            default: comm_en <= dbg_sh[0]; // Access grant
                        endcase
                    end
                    if (ir == 4'h4) begin
                        // Programming over the four test pins only (RULE6)
                        if (prg_sh[19:16] == `JDSP_PRG_CHIP_ERASE) begin
                            locked_after_erase <= 1'b1;
                        end
                        if (prg_sh[19:16] != `JDSP_PRG_WR_DEBUG_FUSE ||
                            !(lock_bit_one | lock_bit_two) || locked_after_erase) begin
                            prog_cmd <= prg_sh[19:16]; // (RULE8)
                            prog_data <= prg_sh[15:0];
                            prog_strobe <= 1'b1;
                        end // (RULE9)
                    end
                end
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Device reset, pin or reset register
    assign cpu_reset = ~rstn_s[1] | reset_reg; // (RULE16)
    ////////////////////////////////////////////////////////////////////////////
    // Pin drive; reset tristates, EXTEST drives latches
    always @(posedge sys_clk) begin
        if (rst || cpu_reset) begin
            pin_out <= {NPINS{1'b0}};
            pin_oe <= {NPINS{1'b0}}; // (RULE15)
        end else if (ir == `JDSP_OP_EXTEST && tap_on) begin
            pin_out <= bs_latch; // (RULE17)
            pin_oe <= {NPINS{1'b1}};
        end else begin
            pin_out <= core_out; // (RULE19)
            pin_oe <= core_oe;
        end
    end
    // Scan paths step only on tck edges seen by sys_clk, never on CPU activity, so they halt with the core clock stopped (RULE20)
    ////////////////////////////////////////////////////////////////////////////
    // Debug comm register and pending flag
    wire comm_hit = cpu_io_sel & debug_enable_fuse & comm_en; // (RULE13)
    assign cpu_io_std_sel = cpu_io_sel & ~comm_hit; // (RULE13)
    wire dbg_read_done = tck_rise & (state == S_UDR) & (ir == `JDSP_OP_PRIV_D)
        & dbg_on & dbg_sh[1];
    always @(posedge sys_clk) begin
        if (rst) begin
            dcr <= `JDSP_DCR_RESET;
            pend <= 1'b0;
            cpu_io_rdata <= 8'h00;
        end else begin
            if (comm_hit && cpu_io_wr) begin
                dcr <= cpu_io_wdata; // (RULE10)
                pend <= 1'b1; // (RULE10)
            end else if (dbg_read_done) begin
                pend <= 1'b0; // (RULE12)
            end
            if (comm_hit && cpu_io_rd) begin
                cpu_io_rdata <= {pend, dcr[6:0]}; // (RULE11)
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Break point unit
    jdsp_break_unit #(
        .AW(AW)
    ) u_brk (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(dbg_on),
        .ctrl(brk_ctrl),
        .bp_addr(bp_addr),
        .cpu_fetch(cpu_fetch),
        .cpu_pc(cpu_pc),
        .cpu_flow_change(cpu_flow_change),
        .cpu_data_acc(cpu_data_acc),
        .cpu_daddr(cpu_daddr),
        .break_req(break_req)
    );
endmodule // jdsp_port

// >>> testbench/jdsp_port_properties.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Port-level timing checks of the test port
module jdsp_port_checker #(
    parameter NPINS = 8
) (
    input wire sys_clk,
    input wire rst,
    input wire tck,
    input wire tdo,
    input wire tdo_oe,
    input wire tap_enable_fuse,
    input wire debug_enable_fuse,
    input wire lock_bit_one,
    input wire lock_bit_two,
    input wire tap_disable_bit,
    input wire ext_reset_n,
    input wire cpu_reset,
    input wire cpu_io_sel,
    input wire cpu_io_std_sel,
    input wire inject_strobe,
    input wire prog_strobe,
    input wire [NPINS-1:0] pin_oe
);
    // One clock domain, synchronous reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_pins_tristate: assert property (cpu_reset |=> pin_oe == {NPINS{1'b0}})
        else $error("pins still driven in reset");
    a_pin_reset: assert property ($fell(ext_reset_n) |-> ##[1:4] cpu_reset)
        else $error("reset pin ignored");
    a_tap_off: assert property ((!tap_enable_fuse || tap_disable_bit) [*2] |-> !tdo_oe)
        else $error("port active while disabled");
    a_debug_gate: assert property (
        (lock_bit_one || lock_bit_two || !debug_enable_fuse) [*2] |-> !inject_strobe)
        else $error("debug access while gated");
    a_std_route: assert property ((cpu_io_sel && !debug_enable_fuse) |-> cpu_io_std_sel)
        else $error("comm register reached without fuse");
    a_inject_pulse: assert property (inject_strobe |=> !inject_strobe)
        else $error("inject strobe too long");
    a_prog_pulse: assert property ($rose(prog_strobe) |=> $fell(prog_strobe))
        else $error("program strobe too long");
    a_tdo_on_fall: assert property ($changed(tdo) |-> !tck)
        else $error("tdo moved with test clock high");
endmodule // jdsp_port_checker
bind jdsp_port jdsp_port_checker #(.NPINS(NPINS)) chk_u (.sys_clk(sys_clk), .rst(rst),
    .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe), .tap_enable_fuse(tap_enable_fuse),
    .debug_enable_fuse(debug_enable_fuse), .lock_bit_one(lock_bit_one),
    .lock_bit_two(lock_bit_two), .tap_disable_bit(tap_disable_bit),
    .ext_reset_n(ext_reset_n), .cpu_reset(cpu_reset), .cpu_io_std_sel(cpu_io_std_sel),
    .cpu_io_sel(cpu_io_sel),
    .inject_strobe(inject_strobe), .prog_strobe(prog_strobe), .pin_oe(pin_oe));

// >>> testbench/jdsp_jtag_tester.sv
`timescale 1ns/1ps
////////////////////////////////////////
// External tester driving only the four test pins
module jdsp_jtag_tester (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire tdo
);
    // Test clock idles low, unrelated to sys_clk
    initial begin
        tck = 0;
        tms = 1;
        tdi = 1;
    end
    // One 80 ns test clock period, tdo read just before the fall
    task step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #40 tck = 1;
        #40 o = tdo;
        tck = 0;
    endtask
    // Navigation bit, data line toggled so no stale level shows
    task walk(input logic m);
        logic o;
        step(m, ~tdi, o);
    endtask
    // Five ones reach Test-Logic-Reset, then Run-Test/Idle
    task go_idle;
        repeat (5) walk(1);
        walk(0);
    endtask
    // Full IR or DR scan from and back to Run-Test/Idle, LSB first
    task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        int i;
        dout = 0;
        walk(1);
        if (ir) walk(1);
        walk(0);
        walk(0);
        for (i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        walk(1);
        walk(0);
    endtask
endmodule // jdsp_jtag_tester

// >>> testbench/jdsp_port_tb.sv
`timescale 1ns/1ps
`include "jdsp_regs.vh"
`define JDSP_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
////////////////////////////////////////
module jdsp_port_tb;
    localparam [31:0] ID = 32'h5A5A_0F01; // Arbitrary identification value
    logic sys_clk = 0, rst = 1, tap_enable_fuse = 1, debug_enable_fuse = 0;
    logic lock_bit_one = 0, lock_bit_two = 0, tap_disable_bit = 0, ext_reset_n = 1;
    logic cpu_io_wr = 0, cpu_io_rd = 0, cpu_io_sel = 0, cpu_fetch = 0, cpu_flow_change = 0;
    logic [7:0] cpu_io_wdata = 0, pin_in = 0, core_out = 0, core_oe = 0;
    logic cpu_data_acc = 0;
    logic [15:0] cpu_pc = 0, cpu_daddr = 0;
    wire tck, tms, tdi, tdo, tdo_oe, cpu_reset, cpu_io_std_sel, inject_strobe, break_req;
    wire prog_strobe;
    wire tdo_line = tdo_oe ? tdo : 1'b1; // Pull-up on released test output
    wire [7:0] cpu_io_rdata, pin_out, pin_oe;
    wire [15:0] inject_instr, prog_data;
    wire [3:0] prog_cmd;
    logic [31:0] exp_q[$], got_q[$], gv, ev, seed = 32'hB076, r, d, a, v;
    int failures = 0, checks_done = 0, i;
    always #4 sys_clk = ~sys_clk;
    jdsp_jtag_tester tester_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
    jdsp_port #(.NPINS(8), .AW(16), .ID_VALUE(ID)) dut_u (.sys_clk(sys_clk), .rst(rst),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .tap_enable_fuse(tap_enable_fuse), .debug_enable_fuse(debug_enable_fuse),
        .lock_bit_one(lock_bit_one), .lock_bit_two(lock_bit_two),
        .tap_disable_bit(tap_disable_bit), .ext_reset_n(ext_reset_n), .cpu_reset(cpu_reset),
        .cpu_io_wr(cpu_io_wr), .cpu_io_rd(cpu_io_rd), .cpu_io_sel(cpu_io_sel),
        .cpu_io_wdata(cpu_io_wdata), .cpu_io_rdata(cpu_io_rdata),
        .cpu_io_std_sel(cpu_io_std_sel), .inject_instr(inject_instr),
        .inject_strobe(inject_strobe), .cpu_fetch(cpu_fetch), .cpu_pc(cpu_pc),
        .cpu_flow_change(cpu_flow_change), .cpu_data_acc(cpu_data_acc), .cpu_daddr(cpu_daddr),
        .break_req(break_req), .prog_cmd(prog_cmd), .prog_data(prog_data),
        .prog_strobe(prog_strobe), .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe),
        .pin_out(pin_out), .pin_oe(pin_oe));
    // Xorshift source for stimulus
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task note(input logic [31:0] e);
        exp_q.push_back(e);
    endtask
    task look(input logic [31:0] g);
        got_q.push_back(g);
    endtask
    // Scan with expected capture under a mask
    task automatic xfer(input logic ir, input int n, input logic [31:0] din,
        input logic [31:0] m, input logic [31:0] e);
        logic [31:0] o;
        exp_q.push_back(e & m);
        tester_u.scan(ir, n, din, o);
        got_q.push_back(o & m);
    endtask
    task op(input logic [3:0] c);
        xfer(1, 4, {28'h0, c}, 32'hF, `JDSP_IR_CAPTURE);
    endtask
    // CPU access of the comm location, read result logged
    task cpu_acc(input logic wr, input logic [7:0] wd);
        @(negedge sys_clk) {cpu_io_sel, cpu_io_wr, cpu_io_rd, cpu_io_wdata} = {1'b1, wr, ~wr, wd};
        @(negedge sys_clk) {cpu_io_sel, cpu_io_wr, cpu_io_rd} = 3'h0;
        @(negedge sys_clk) if (!wr) look(cpu_io_rdata);
    endtask
    // Bare select held, routing of the access logged
    task std_probe(input logic e);
        @(negedge sys_clk) cpu_io_sel = 1;
        @(negedge sys_clk) note(e);
        look(cpu_io_std_sel);
        cpu_io_sel = 0;
    endtask
    // Strobe and break results appear here
    always @(posedge sys_clk) begin
        if (inject_strobe === 1'b1) got_q.push_back({16'h0, inject_instr});
        if (prog_strobe === 1'b1) got_q.push_back({12'h0, prog_cmd, prog_data});
        if (break_req === 1'b1) got_q.push_back(32'h1);
    end
    // Oldest expectation against oldest result
    always @(posedge sys_clk) begin
        if (got_q.size() > 0) begin
            gv = got_q.pop_front();
            ev = (exp_q.size() > 0) ? exp_q.pop_front() : {32{1'bx}};
            `JDSP_CHK(gv, ev)
        end
    end
    task done(input string s);
        repeat (8) @(negedge sys_clk);
        $display("test %s finished", s);
    endtask
    task conclude;
        failures += exp_q.size();
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #400000 failures++;
        conclude;
    end
    initial begin
        repeat (16) @(negedge sys_clk);
        rst = 0;
        std_probe(1);
        debug_enable_fuse = 1;
        tester_u.go_idle;
        xfer(0, 32, rnd(), 32'hFFFFFFFF, ID);
        op(`JDSP_OP_BYPASS);
        r = rnd();
        xfer(0, 2, r, 32'h3, {30'h0, r[0], 1'b0});
        done("ident_bypass");
        std_probe(1);
        op(`JDSP_OP_PRIV_D);
        xfer(0, 32, 32'h1, 32'hFF, 32'h0);
        std_probe(0);
        d = rnd();
        cpu_acc(1, d[7:0]);
        note({24'h0, 1'b1, d[6:0]});
        cpu_acc(0, 8'h00);
        op(`JDSP_OP_PRIV_D);
        xfer(0, 32, 32'h3, 32'hFF, {24'h0, 1'b1, d[6:0]});
        note({24'h0, 1'b0, d[6:0]});
        cpu_acc(0, 8'h00);
        op(`JDSP_OP_PRIV_A);
        r = rnd();
        note({16'h0, r[15:0]});
        xfer(0, 32, r, 32'hFF, {24'h0, 1'b0, d[6:0]});
        done("comm_inject");
        a = rnd() | 32'h1;
        op(`JDSP_OP_PRIV_C);
        xfer(0, 32, {16'h0, a[15:0]}, 32'hFF, {24'h0, 1'b0, d[6:0]});
        xfer(0, 32, {14'h0, 2'h3, a[15:0]}, 32'hFF, {24'h0, 1'b0, d[6:0]});
        op(`JDSP_OP_PRIV_B);
        xfer(0, 32, {29'h0, `JDSP_BM_3P1D} << `JDSP_BRK_MODE_LSB | 32'h1, 0, 0);
        note(1);
        @(negedge sys_clk) cpu_flow_change = 1;
        @(negedge sys_clk) cpu_flow_change = 0;
        repeat (4) @(negedge sys_clk);
        note(1);
        cpu_pc = a[15:0];
        cpu_fetch = 1;
        @(negedge sys_clk) cpu_fetch = 0;
        note(1);
        {cpu_daddr, cpu_data_acc} = {a[15:0], 1'b1};
        @(negedge sys_clk) cpu_data_acc = 0;
        done("break");
        op(`JDSP_OP_RESET);
        xfer(0, 1, 32'h1, 32'h1, 32'h0);
        repeat (2) @(negedge sys_clk);
        note(1);
        look(cpu_reset);
        note(0);
        look(pin_oe);
        xfer(0, 1, 32'h0, 32'h1, 32'h1);
        note(0);
        look(cpu_reset);
        ext_reset_n = 0;
        repeat (5) @(negedge sys_clk);
        note(1);
        look(cpu_reset);
        ext_reset_n = 1;
        done("reset");
        r = rnd();
        {core_out, core_oe, pin_in} = r[23:0];
        v = rnd();
        op(`JDSP_OP_SAMPLE);
        xfer(0, 8, v, 32'hFF, pin_in);
        op(`JDSP_OP_EXTEST);
        repeat (2) @(negedge sys_clk);
        note(v[7:0]);
        look(pin_out);
        note(8'hFF);
        look(pin_oe);
        op(`JDSP_OP_BYPASS);
        done("scan_ring");
        lock_bit_one = 1;
        r = rnd();
        op(4'h4);
        xfer(0, 20, {12'h0, `JDSP_PRG_WR_DEBUG_FUSE, r[15:0]}, 0, 0);
        for (i = 1; i < 4; i++) begin
            note({12'h0, i[3:0], r[15:0]});
            xfer(0, 20, {12'h0, i[3:0], r[15:0]}, 0, 0);
        end
        done("program");
        tap_disable_bit = 1;
        xfer(0, 32, rnd(), 32'hFFFFFFFF, 32'hFFFFFFFF);
        done("tap_off");
        conclude;
    end
endmodule // jdsp_port_tb
